// [rtl/flash_status_pkg.sv]
// Purpose: Constants for the flash write-status polling controller
// Assumes: 250 MHz clock, byte-wide flash data bus
// Notes: Bit positions of the status byte and strobe timing counts
package flash_status_pkg;
    localparam int CLK_MHZ = 250;
    // Status byte bit positions
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int LIMIT_BIT = 5;
    localparam int TIMER_BIT = 3;
    localparam int SECTOR_BIT = 2;
    // Read strobe low time and gap between cycles, in ns
    localparam int STROBE_NS = 80;
    localparam int GAP_NS = 20;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
    // Reset command byte and its address
    localparam logic [7:0] RESET_CMD = 8'hf0;
    localparam logic [21:0] RESET_ADDR = 22'h000000;
    // Result codes
    localparam logic [1:0] RES_DONE = 2'h0;
    localparam logic [1:0] RES_FAIL = 2'h1;
    localparam logic [1:0] RES_BUSY = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE, ST_STROBE, ST_GAP, ST_EVAL, ST_RESET
    } poll_state_t;
endpackage : flash_status_pkg

// [rtl/flash_status_poller.sv]
// Purpose: Host controller running the toggle-bit status check on a flash bank
// Assumes: Flash data lines sampled synchronously; one clock domain
// Notes: Each poll request restarts with a fresh double read
`timescale 1ns/1ps
module flash_status_poller #(
    parameter int ADDR_W = 22
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // User side
    input wire logic poll_req_in,
    input wire logic [ADDR_W-1:0] poll_addr_in,
    output logic poll_ready_out,
    output logic done_out,
    output logic [1:0] result_out,
    output logic [7:0] status_out,
    // Flash pins
    output logic [ADDR_W-1:0] addr_out,
    output logic flash_sel_n_out,
    output logic out_en_n_out,
    output logic write_en_n_out,
    input wire logic [7:0] status_byte_lines_in,
    output logic [7:0] data_out,
    output logic data_oe_n_out,
    input wire logic ready_busy_n_in
);
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(flash_status_pkg::STROBE_CYC - 1);
    localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(flash_status_pkg::GAP_CYC - 1);

    flash_status_pkg::poll_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [7:0] first_q, first_d;
    logic [7:0] last_q, last_d;
    logic [1:0] nreads_q, nreads_d;
    logic limit_seen_q, limit_seen_d;
    logic done_q, done_d;
    logic [1:0] result_q, result_d;
    logic reset_wr_q, reset_wr_d;
    logic toggled;

    // Toggle compare between the two latest reads
    assign toggled = first_q[flash_status_pkg::TOGGLE_BIT] != last_q[flash_status_pkg::TOGGLE_BIT];

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        first_d = first_q;
        last_d = last_q;
        nreads_d = nreads_q;
        limit_seen_d = limit_seen_q;
        done_d = 1'b0;
        result_d = result_q;
        reset_wr_d = reset_wr_q;
        unique case (state_q)
            flash_status_pkg::ST_IDLE: begin
                if (poll_req_in) begin
                    // Fresh double read on every request at the busy bank address
                    addr_d = poll_addr_in;
                    nreads_d = 2'h0;
                    limit_seen_d = 1'b0;
                    reset_wr_d = 1'b0;
                    cnt_d = '0;
                    state_d = flash_status_pkg::ST_STROBE;
                end
            end
            flash_status_pkg::ST_STROBE: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == STROBE_LAST) begin
                    cnt_d = '0;
                    state_d = flash_status_pkg::ST_GAP;
                    if (!reset_wr_q) begin
                        // One sample per completed read cycle
                        first_d = last_q;
                        last_d = status_byte_lines_in;
                        if (nreads_q != 2'h3) begin
                            nreads_d = nreads_q + 1'b1;
                        end
                    end
                end
            end
            flash_status_pkg::ST_GAP: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == GAP_LAST) begin
                    cnt_d = '0;
                    state_d = reset_wr_q ? flash_status_pkg::ST_IDLE : flash_status_pkg::ST_EVAL;
                    if (reset_wr_q) begin
                        // Release the data lines once the command is written
                        reset_wr_d = 1'b0;
                        done_d = 1'b1;
                    end
                end
            end
            flash_status_pkg::ST_EVAL: begin
                state_d = flash_status_pkg::ST_STROBE;
                // Erase timer flag is left to the user; no sector commands here
                if (nreads_q >= 2'h2) begin
                    if (!toggled) begin
                        // Unchanged toggle bit: operation finished
                        result_d = flash_status_pkg::RES_DONE;
                        done_d = 1'b1;
                        state_d = flash_status_pkg::ST_IDLE;
                    end else if (limit_seen_q) begin
                        // Still toggling after limit flag: fail, send reset
                        result_d = flash_status_pkg::RES_FAIL;
                        reset_wr_d = 1'b1;
                        state_d = flash_status_pkg::ST_RESET;
                    end else if (last_q[flash_status_pkg::LIMIT_BIT]) begin
                        // Limit flag high: one more read to recheck
                        limit_seen_d = 1'b1;
                    end else begin
                        result_d = flash_status_pkg::RES_BUSY;
                    end
                end
            end
            flash_status_pkg::ST_RESET: begin
                // Reset command write cycle uses the strobe timing
                cnt_d = '0;
                state_d = flash_status_pkg::ST_STROBE;
            end
            default: state_d = flash_status_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= flash_status_pkg::ST_IDLE;
            cnt_q <= '0;
            addr_q <= '0;
            first_q <= 8'h00;
            last_q <= 8'h00;
            nreads_q <= 2'h0;
            limit_seen_q <= 1'b0;
            done_q <= 1'b0;
            result_q <= flash_status_pkg::RES_DONE;
            reset_wr_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            first_q <= first_d;
            last_q <= last_d;
            nreads_q <= nreads_d;
            limit_seen_q <= limit_seen_d;
            done_q <= done_d;
            result_q <= result_d;
            reset_wr_q <= reset_wr_d;
        end
    end

    // Flash strobes: reads end each cycle by raising select and output enable
    logic in_strobe;
    assign in_strobe = state_q == flash_status_pkg::ST_STROBE;
    assign addr_out = reset_wr_q ? ADDR_W'(flash_status_pkg::RESET_ADDR) : addr_q;
    assign flash_sel_n_out = !in_strobe;
    assign out_en_n_out = !(in_strobe && !reset_wr_q);
    assign write_en_n_out = !(in_strobe && reset_wr_q);
    assign data_out = flash_status_pkg::RESET_CMD;
    assign data_oe_n_out = !reset_wr_q;
    assign poll_ready_out = state_q == flash_status_pkg::ST_IDLE;
    assign done_out = done_q;
    assign result_out = result_q;
    assign status_out = last_q; // Timer flag handed on for sector command

    // Assertions
    // Named steps of the failure path
    sequence s_fail_seen;
        state_q == flash_status_pkg::ST_EVAL && state_d == flash_status_pkg::ST_RESET;
    endsequence
    sequence s_reset_write;
        !write_en_n_out && !flash_sel_n_out && data_out == flash_status_pkg::RESET_CMD;
    endsequence
    a_done_means_idle: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        done_out |-> state_q == flash_status_pkg::ST_IDLE)
        else $error("done outside idle");
    a_no_drive_on_read: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !out_en_n_out |-> data_oe_n_out && write_en_n_out)
        else $error("bus contention");
    a_fail_sends_reset: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        s_fail_seen |-> ##2 s_reset_write)
        else $error("reset command missing");
    a_restart_fresh: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (poll_ready_out && poll_req_in) |=> nreads_q == 2'h0 && !limit_seen_q)
        else $error("poll did not restart");
    a_done_needs_two: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (done_d && !reset_wr_q) |-> nreads_q >= 2'h2 && !toggled)
        else $error("done before double read");
    a_status_sampled: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (state_q == flash_status_pkg::ST_STROBE && cnt_q == STROBE_LAST && !reset_wr_q)
        |=> status_out == $past(status_byte_lines_in))
        else $error("status byte not taken");
    a_write_holds_data: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        $rose(write_en_n_out) |-> !data_oe_n_out && data_out == flash_status_pkg::RESET_CMD)
        else $error("command data released early");
    a_result_on_done: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        done_out |-> result_out != flash_status_pkg::RES_BUSY)
        else $error("done with busy result");
endmodule : flash_status_poller

// [tb/flash_status_model.sv]
// Purpose: Flash status responder seen by the poller
// Assumes: Driven by the bench through begin_op
// Notes: Released lines show the inverse of the last byte
`timescale 1ns/1ps
module flash_status_model (
    // Flash pins
    input wire logic sel_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic [7:0] bus_in,
    output logic [7:0] data_out,
    output logic ready_busy_n_out
);
    int left = 0;
    int reads = 0;
    int writes = 0;
    bit stuck = 1'b0;
    logic toggle_q = 1'b0;
    logic [7:0] last = 8'h00;
    logic [7:0] status;
    wire busy = stuck || (left > 0);
    wire rd = !sel_n_in && !oe_n_in && we_n_in;
    wire wr = !sel_n_in && !we_n_in;
    task automatic begin_op(input int n, input bit fail);
        left = n; // Toggling span, counted in finished reads
        stuck = fail;
        reads = 0;
        writes = 0;
    endtask : begin_op
    // Status byte; sector toggle stays still during program
    assign status = {~busy, toggle_q, stuck, 1'b0, 1'b1, 1'b0, 2'h0};
    // Busy line driven low while busy and high when ready
    assign ready_busy_n_out = busy ? 1'b0 : 1'b1;
    assign data_out = rd ? status : ~last;
    // Each finished read advances the toggle while busy
    always @(negedge rd) begin
        last = status;
        reads++;
        if (busy) toggle_q = ~toggle_q;
        if (left > 0) left--;
    end
    // Reset command ends a failed operation
    always @(negedge wr) begin
        writes++; // Other command bytes are ignored
        if (bus_in === 8'hf0) begin
            stuck = 1'b0;
            left = 0;
        end
    end
endmodule : flash_status_model

// [tb/flash_status_poller_tb.sv]
// Purpose: Self-checking bench for the status poller
// Assumes: Model answers every read with a status byte
// Notes: Scenarios cover done, long busy, failure and restart
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module flash_status_poller_tb;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic poll_req_in = 1'b0;
    logic [21:0] poll_addr_in = 22'h000000;
    logic poll_ready_out, done_out, flash_sel_n_out, out_en_n_out, write_en_n_out;
    logic data_oe_n_out, ready_busy_n;
    logic [1:0] result_out;
    logic [7:0] status_out, data_out, dev_data, lines;
    logic [21:0] addr_out;
    int num_errors = 0;
    int num_checks = 0;
    always #2 clk_in = ~clk_in;
    assign lines = data_oe_n_out ? dev_data : data_out;
    flash_status_poller #(.ADDR_W(22)) i_flash_status_poller (.clk_in(clk_in),
        .arst_n_in(arst_n_in), .poll_req_in(poll_req_in), .poll_addr_in(poll_addr_in),
        .poll_ready_out(poll_ready_out), .done_out(done_out), .result_out(result_out),
        .status_out(status_out), .addr_out(addr_out), .flash_sel_n_out(flash_sel_n_out),
        .out_en_n_out(out_en_n_out), .write_en_n_out(write_en_n_out),
        .status_byte_lines_in(lines), .data_out(data_out), .data_oe_n_out(data_oe_n_out),
        .ready_busy_n_in(ready_busy_n));
    flash_status_model i_flash_status_model (.sel_n_in(flash_sel_n_out),
        .oe_n_in(out_en_n_out), .we_n_in(write_en_n_out), .bus_in(lines),
        .data_out(dev_data), .ready_busy_n_out(ready_busy_n));
    task automatic test_done();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    task automatic poll(input int n, input bit fail);
        int k;
        k = 0;
        i_flash_status_model.begin_op(n, fail);
        `CHK(poll_ready_out, 1'b1)
        poll_req_in = 1'b1;
        poll_addr_in = 22'h012345;
        @(posedge clk_in);
        #1 poll_req_in = 1'b0;
        `CHK(addr_out, 22'h012345)
        while (done_out !== 1'b1 && k < 5000) begin
            @(posedge clk_in);
            #1 k++;
        end
        `CHK(done_out, 1'b1)
    endtask : poll
    task automatic test_idle();
        poll(0, 1'b0);
        `CHK(result_out, flash_status_pkg::RES_DONE)
        `CHK(i_flash_status_model.reads, 2)
    endtask : test_idle
    task automatic test_busy();
        poll(5, 1'b0);
        `CHK(result_out, flash_status_pkg::RES_DONE)
        `CHK(i_flash_status_model.reads, 7)
        `CHK(i_flash_status_model.writes, 0)
        `CHK(ready_busy_n, 1'b1)
    endtask : test_busy
    task automatic test_fail();
        poll(1, 1'b1);
        `CHK(result_out, flash_status_pkg::RES_FAIL)
        `CHK(i_flash_status_model.reads, 3)
        `CHK(i_flash_status_model.writes, 1)
        `CHK(i_flash_status_model.stuck, 1'b0)
        `CHK(status_out[flash_status_pkg::LIMIT_BIT], 1'b1)
    endtask : test_fail
    task automatic test_again();
        @(posedge clk_in);
        #1 poll(0, 1'b0);
        `CHK(result_out, flash_status_pkg::RES_DONE)
        `CHK(i_flash_status_model.reads, 2)
    endtask : test_again
    task automatic test_restart();
        int k;
        k = 0;
        i_flash_status_model.begin_op(50, 1'b0);
        poll_req_in = 1'b1;
        @(posedge clk_in);
        #1 poll_req_in = 1'b0;
        while (result_out !== flash_status_pkg::RES_BUSY && k < 500) begin
            @(posedge clk_in);
            #1 k++;
        end
        `CHK(result_out, flash_status_pkg::RES_BUSY)
        arst_n_in = 1'b0;
        @(posedge clk_in);
        #1 `CHK(flash_sel_n_out, 1'b1)
        arst_n_in = 1'b1;
        @(posedge clk_in);
        #1 poll(0, 1'b0);
        `CHK(result_out, flash_status_pkg::RES_DONE)
        `CHK(i_flash_status_model.reads, 2)
    endtask : test_restart
    initial begin
        #100000;
        num_errors++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge clk_in);
        #1 arst_n_in = 1'b1;
        @(posedge clk_in);
        #1 test_idle();
        test_busy();
        test_fail();
        test_again();
        test_restart();
        test_done();
    end
endmodule : flash_status_poller_tb
